// File: verilog/erpc_defs.svh
// Constants of the external request pin conditioning block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef ERPC_DEFS_SVH
`define ERPC_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets on the Avalon-MM slave.
// ----------------------------------------------------------------
`define ERPC_OFS_CONTROL 4'h0
`define ERPC_OFS_STATUS  4'h4
`define ERPC_OFS_MASK    4'h8
`define ERPC_OFS_SERVICE 4'hC

// ----------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------
`define ERPC_BIT_EDGE_SELECT    7
`define ERPC_BIT_CONNECT_ENABLE 6
`define ERPC_BIT_EV_REQUEST     0
`define ERPC_BIT_EV_REJECT      1
`define ERPC_BIT_SERVICE        0

// ----------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------
`define ERPC_RST_EDGE_SELECT    1'b0
`define ERPC_RST_CONNECT_ENABLE 1'b1
`define ERPC_RST_EVENTS         2'h0

`endif

// File: verilog/erpc_pkg.sv
// Types shared by the external request pin conditioning block.
// Assumes the constants header is on the include path.
`include "erpc_defs.svh"
package erpc_pkg;
  // Bus answer sequencer states.
  typedef enum logic {
    BUS_IDLE,
    BUS_ANSWER
  } erpc_bus_state_t;

  // Event bits held in the status and mask registers.
  typedef logic [1:0] erpc_events_t;
endpackage : erpc_pkg

// File: verilog/erpc_pin_if.sv
// Carrier between the pin conditioner and the block's top module.
// Assumes both ends run on the same bus clock.
`timescale 1ns/100ps
interface erpc_pin_if;
  logic level;  // Filtered pin level, high when the pin rests high.
  logic fall;   // One-cycle pulse on a filtered falling transition.

  modport src (output level, output fall);
  modport dst (input level, input fall);
endinterface : erpc_pin_if

// File: verilog/erpc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and fall detect.
// Assumes the pin is asynchronous to clk_sys_i and idles high.
`timescale 1ns/100ps
module erpc_pin_sync
  import erpc_pkg::*;
(
  input  wire logic clk_sys_i,   // Bus clock.
  input  wire logic rst_n_i,     // Asynchronous reset, active low.
  input  wire logic pin_i,       // Raw external request pin.
  erpc_pin_if.src   pin_if       // Filtered level and fall pulse.
);
  // ----------------------------------------------------------------
  // Synchroniser chain and filtered level.
  // ----------------------------------------------------------------
  logic meta;        // First stage, read only by the second stage.
  logic sync2;       // Second stage.
  logic sync3;       // Third stage.
  logic level;       // Level accepted once stages two and three agree.
  logic fall;        // Registered fall pulse.
  logic next_level;  // Next accepted level.
  logic next_fall;   // Next fall pulse.

  // A change counts only when two settled stages agree.
  always_comb begin
    next_level = level;
    if (sync2 == sync3) begin
      next_level = sync3;
    end
    next_fall = level & ~next_level;
  end

  // The chain resets to the idle-high level so no false fall appears.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta  <= 1'b1;
      sync2 <= 1'b1;
      sync3 <= 1'b1;
      level <= 1'b1;
      fall  <= 1'b0;
    end else begin
      meta  <= pin_i;
      sync2 <= meta;
      sync3 <= sync2;
      level <= next_level;
      fall  <= next_fall;
    end
  end

  assign pin_if.level = level;
  assign pin_if.fall  = fall;

  // A fall pulse always marks a high-to-low step of the level.
  fall_marks_step_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    fall |-> (!level && $past(level)))
    else $error("Fall pulse without a level step.");
endmodule : erpc_pin_sync

// File: verilog/erpc_top.sv
// External maskable request pin conditioning with Avalon-MM registers.
// Assumes one bus clock, a same-clock CPU service strobe and mode bit.
//
// Function
// - Edge select readable; write once unless special.
// - Edge mode: only falling transitions raise requests.
// - Latched fall pending until reset, service or level mode.
// - Level mode: low level requests while it persists.
// - Connect enable gates pin into request logic.
// - Request is maskable by processor interrupt mask.
`timescale 1ns/100ps
`include "erpc_defs.svh"
module erpc_top
  import erpc_pkg::*;
(
  input  wire logic        clk_sys_i,        // Bus clock, 125 MHz.
  input  wire logic        rst_n_i,          // Asynchronous reset.
  input  wire logic        request_pin_n_i,  // External request pin.
  input  wire logic        special_mode_i,   // High in special mode.
  input  wire logic        cpu_int_mask_i,   // Processor masks requests.
  input  wire logic        service_ack_i,    // Request serviced pulse.
  input  wire logic [3:0]  address,          // Byte address.
  input  wire logic        read,             // Avalon read.
  input  wire logic        write,            // Avalon write.
  input  wire logic [3:0]  byteenable,       // Avalon byte enables.
  input  wire logic [31:0] writedata,        // Avalon write data.
  output logic      [31:0] readdata,         // Avalon read data.
  output logic             waitrequest,      // Avalon wait request.
  output logic             cpu_request_o,    // Request to processor.
  output logic             irq_o             // Status interrupt.
);
  // ----------------------------------------------------------------
  // Pin conditioning.
  // ----------------------------------------------------------------
  erpc_pin_if pin_if ();  // Filtered pin from the synchroniser.

  erpc_pin_sync u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (request_pin_n_i),
    .pin_if    (pin_if)
  );

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  erpc_bus_state_t bus_state;       // Answer sequencer.
  erpc_bus_state_t next_bus_state;
  logic         edge_select;        // High selects falling-edge mode.
  logic         next_edge_select;
  logic         connect_enable;     // High connects the pin.
  logic         next_connect_enable;
  logic         edge_written;       // A normal-mode write was used.
  logic         next_edge_written;
  logic         edge_pending;       // Latched falling transition.
  logic         next_edge_pending;
  logic         request;            // Internal request before masking.
  logic         next_request;
  erpc_events_t status;             // Sticky events.
  erpc_events_t next_status;
  erpc_events_t mask;               // Event enables for irq_o.
  erpc_events_t next_mask;
  erpc_events_t read_clear;         // Status bits reported by a read.
  erpc_events_t next_read_clear;
  logic [31:0]  next_readdata;
  logic         next_waitrequest;
  logic         next_cpu_request;
  logic         next_irq;

  // Request completes at this edge: waitrequest is already low.
  logic         done_wr;            // Write takes effect now.
  logic         done_rd;            // Read data are taken now.
  logic         wr_control;         // Control byte written now.
  logic         wr_service;         // Service bit written now.
  logic         service;            // Pending edge is retired now.
  logic         set_request;        // New request rising.
  logic         set_reject;         // A control write was refused.

  assign done_wr = (bus_state == BUS_ANSWER) & write;
  assign done_rd = (bus_state == BUS_ANSWER) & read;
  assign wr_control = done_wr & byteenable[0]
                      & (address == `ERPC_OFS_CONTROL);
  assign wr_service = done_wr & byteenable[0]
                      & (address == `ERPC_OFS_SERVICE)
                      & writedata[`ERPC_BIT_SERVICE];
  assign service = service_ack_i | wr_service;

  // ----------------------------------------------------------------
  // Bus sequencer: one wait cycle, then one answer cycle.
  // ----------------------------------------------------------------
  // A fixed single wait state keeps read data registered and lets a
  // read-to-clear act only on bits that the master actually saw.
  always_comb begin
    next_bus_state   = bus_state;
    next_waitrequest = 1'b1;
    next_readdata    = readdata;
    next_read_clear  = '0;
    case (bus_state)
      BUS_IDLE: begin
        if (read | write) begin
          next_bus_state   = BUS_ANSWER;
          next_waitrequest = 1'b0;
          next_readdata    = 32'h0000_0000;
          if (read) begin
            if (address == `ERPC_OFS_CONTROL) begin
              next_readdata[`ERPC_BIT_EDGE_SELECT] = edge_select;
              next_readdata[`ERPC_BIT_CONNECT_ENABLE] =
                connect_enable;
            end else if (address == `ERPC_OFS_STATUS) begin
              next_readdata[1:0] = status;
              next_read_clear    = status;
            end else if (address == `ERPC_OFS_MASK) begin
              next_readdata[1:0] = mask;
            end else begin
              next_readdata = 32'h0000_0000;  // Unmapped reads zero.
            end
          end
        end
      end
      BUS_ANSWER: begin
        next_bus_state  = BUS_IDLE;
        next_read_clear = read_clear;
      end
      default: begin
        next_bus_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_state   <= BUS_IDLE;
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
      read_clear  <= 2'h0;
    end else begin
      bus_state   <= next_bus_state;
      waitrequest <= next_waitrequest;
      readdata    <= next_readdata;
      read_clear  <= next_read_clear;
    end
  end

  // ----------------------------------------------------------------
  // Control register.
  // ----------------------------------------------------------------
  // In normal mode the first control write spends the edge select
  // permission even if it leaves the value unchanged.
  always_comb begin
    next_edge_select    = edge_select;
    next_connect_enable = connect_enable;
    next_edge_written   = edge_written;
    set_reject          = 1'b0;
    if (wr_control) begin
      next_connect_enable =
        writedata[`ERPC_BIT_CONNECT_ENABLE];
      if (special_mode_i) begin
        next_edge_select = writedata[`ERPC_BIT_EDGE_SELECT];
      end else if (!edge_written) begin
        next_edge_select  = writedata[`ERPC_BIT_EDGE_SELECT];
        next_edge_written = 1'b1;
      end else begin
        set_reject = 1'b1;  // Later normal-mode edge select writes are refused.
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      edge_select    <= `ERPC_RST_EDGE_SELECT;
      connect_enable <= `ERPC_RST_CONNECT_ENABLE;
      edge_written   <= 1'b0;
    end else begin
      edge_select    <= next_edge_select;
      connect_enable <= next_connect_enable;
      edge_written   <= next_edge_written;
    end
  end

  // ----------------------------------------------------------------
  // Request logic.
  // ----------------------------------------------------------------
  // A fall arriving with a service wins, so that no edge is lost.
  always_comb begin
    next_edge_pending = edge_pending;
    if (service) begin
      next_edge_pending = 1'b0;
    end
    if (edge_select & connect_enable & pin_if.fall) begin
      next_edge_pending = 1'b1;
    end
    if (!edge_select) begin
      next_edge_pending = 1'b0;  // Nothing latches in level mode.
    end
    if (!connect_enable) begin
      next_request = 1'b0;
    end else if (edge_select) begin
      next_request = next_edge_pending;
    end else begin
      next_request = ~pin_if.level;
    end
    next_cpu_request = next_request & ~cpu_int_mask_i;
    set_request      = next_request & ~request;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      edge_pending  <= 1'b0;
      request       <= 1'b0;
      cpu_request_o <= 1'b0;
    end else begin
      edge_pending  <= next_edge_pending;
      request       <= next_request;
      cpu_request_o <= next_cpu_request;
    end
  end

  // ----------------------------------------------------------------
  // Status, mask and interrupt.
  // ----------------------------------------------------------------
  // A read clears only the bits it returned, and a new event wins.
  always_comb begin
    next_status = status;
    if (done_rd) begin
      next_status = status & ~read_clear;
    end
    next_status[`ERPC_BIT_EV_REQUEST] =
      next_status[`ERPC_BIT_EV_REQUEST] | set_request;
    next_status[`ERPC_BIT_EV_REJECT] =
      next_status[`ERPC_BIT_EV_REJECT] | set_reject;
    next_mask = mask;
    if (done_wr & byteenable[0] & (address == `ERPC_OFS_MASK)) begin
      next_mask = writedata[1:0];
    end
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status <= `ERPC_RST_EVENTS;
      mask   <= `ERPC_RST_EVENTS;
      irq_o  <= 1'b0;
    end else begin
      status <= next_status;
      mask   <= next_mask;
      irq_o  <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  edge_write_once_a: assert property (
    (edge_written && !special_mode_i && wr_control) |=>
      $stable(edge_select))
    else $error("Edge select changed after its single write.");

  level_ignored_edge_a: assert property (
    (edge_select && !edge_pending && !pin_if.fall && !service
     && $stable(edge_select)) |=> !edge_pending)
    else $error("Edge mode latched without a falling transition.");

  pending_holds_a: assert property (
    (edge_pending && edge_select && !service) ##1 $stable(edge_select)
      |-> edge_pending)
    else $error("Pending edge lost without service.");

  level_request_a: assert property (
    (!edge_select && connect_enable && !pin_if.level) |=> request)
    else $error("Low level in level mode raised no request.");

  disconnect_quiet_a: assert property (
    !connect_enable |=> !request)
    else $error("Request raised while the pin is disconnected.");

  cpu_mask_a: assert property (
    cpu_int_mask_i |=> !cpu_request_o)
    else $error("Masked request reached the processor.");

  answer_one_wait_a: assert property (
    ($rose(read) || $rose(write)) && waitrequest |=> !waitrequest ##1
      waitrequest)
    else $error("Bus answer not after exactly one wait cycle.");

  fall_to_request_a: assert property (
    (edge_select && connect_enable && pin_if.fall && $stable(edge_select)
     && $stable(connect_enable)) |=> request)
    else $error("Falling transition raised no request.");

  edge_request_c: cover property (
    edge_select && pin_if.fall ##1 request ##[1:20] service);
  level_request_c: cover property (!edge_select && request);
  reject_c: cover property (set_reject);
  irq_c: cover property (irq_o ##[1:10] done_rd);
endmodule : erpc_top

// File: bench/erpc_pin_model.sv
// Far-side model: the source that pulls the request pin low.
// Assumes the bench commands it on the rising edge of the bus clock.
`timescale 1ns/100ps
module erpc_pin_model (
  input  wire logic clk_sys_i,  // Bus clock, sets when the line moves.
  input  wire logic pull_low_i, // High while the source asserts.
  output logic      pin_n_o     // Request line, active low.
);
  // ----------------------------------------------------------------
  // Open-drain driver with pull-up.
  // ----------------------------------------------------------------
  // Released, the line goes to the pull-up level, never a held value.
  initial pin_n_o = 1'b1;
  always @(posedge clk_sys_i) begin
    pin_n_o <= pull_low_i ? 1'b0 : 1'b1;
  end
endmodule : erpc_pin_model

// File: bench/erpc_top_tb.sv
// Self-checking bench for the request pin conditioning block.
// Assumes the pin model file and the design files are compiled first.
`timescale 1ns/100ps
module erpc_top_tb;
  import erpc_pkg::*;
  logic        clk_sys_i;       // Bus clock, 8 ns period.
  logic        rst_n_i;         // Reset, active low.
  logic        pull_low;        // Command to the pin source.
  wire         request_pin_n;   // Pin as the model drives it.
  logic        special_mode;    // Special mode select.
  logic        cpu_int_mask;    // Processor mask.
  logic        service_ack;     // Service pulse.
  logic [3:0]  address;         // Bus address.
  logic        read;            // Bus read.
  logic        write;           // Bus write.
  logic [31:0] writedata;       // Bus write data.
  logic [31:0] readdata;        // Bus read data.
  logic        waitrequest;     // Bus wait request.
  logic        cpu_request;     // Request to the processor.
  logic        irq;             // Status interrupt.
  logic [31:0] rd;              // Last value read.
  int          fails;           // Mismatches seen.
  int          total_checks;    // Comparisons made.

  erpc_pin_model pin (.clk_sys_i(clk_sys_i), .pull_low_i(pull_low),
                      .pin_n_o(request_pin_n));
  erpc_top uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .request_pin_n_i(request_pin_n), .special_mode_i(special_mode),
    .cpu_int_mask_i(cpu_int_mask), .service_ack_i(service_ack),
    .address(address), .read(read), .write(write), .byteenable(4'hF),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .cpu_request_o(cpu_request),
    .irq_o(irq));

  // ----------------------------------------------------------------
  // Clock and watchdog.
  // ----------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // The tests need well under 1000 cycles; 5000 leaves ample margin.
  initial begin
    #40000;
    fails = fails + 1;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  // Compares a value seen with the value expected and counts both.
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Lets n edges pass and stops mid-cycle, where outputs are settled.
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask : idle

  // One bus transfer; held until the edge that sees waitrequest low.
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int guard;
    guard = 0;
    @(posedge clk_sys_i);
    address   <= a;
    writedata <= d;
    read      <= ~wr;
    write     <= wr;
    // Right after an edge the bench sees what the design sampled there.
    do begin
      @(posedge clk_sys_i);
      guard = guard + 1;
    end while (waitrequest !== 1'b0 && guard < 50);
    if (guard >= 50) fails = fails + 1;
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  // Pin command and service pulse, both launched on a rising edge.
  task automatic pin_low(input logic v);
    @(posedge clk_sys_i);
    pull_low <= v;
  endtask : pin_low
  task automatic serve;
    @(posedge clk_sys_i);
    service_ack <= 1'b1;
    @(posedge clk_sys_i);
    service_ack <= 1'b0;
  endtask : serve

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------
  initial begin
    fails = 0; total_checks = 0; rst_n_i = 1'b0; pull_low = 1'b0;
    special_mode = 1'b0; cpu_int_mask = 1'b0; service_ack = 1'b0;
    address = 4'h0; read = 1'b0; write = 1'b0; writedata = 32'h0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    // Reset values: level mode, pin connected.
    bus(1'b0, `ERPC_OFS_CONTROL, 32'h0);
    check("control", rd, 32'h00000040);
    idle(0);
    check("wait idle", waitrequest, 1'b1);
    bus(1'b0, `ERPC_OFS_STATUS, 32'h0);
    check("status", rd, 32'h00000000);
    $display("test reset done");
    // Level mode: request follows the low level, subject to the mask.
    bus(1'b1, `ERPC_OFS_MASK, 32'h00000001);
    pin_low(1'b1);
    idle(8);
    check("level request", cpu_request, 1'b1);
    check("irq", irq, 1'b1);
    idle(20);
    check("level held", cpu_request, 1'b1);
    @(posedge clk_sys_i);
    cpu_int_mask <= 1'b1;
    idle(2);
    check("masked", cpu_request, 1'b0);
    @(posedge clk_sys_i);
    cpu_int_mask <= 1'b0;
    bus(1'b0, `ERPC_OFS_STATUS, 32'h0);
    check("status set", rd, 32'h00000001);
    idle(1);
    check("irq clear", irq, 1'b0);
    pin_low(1'b0);
    idle(8);
    check("level gone", cpu_request, 1'b0);
    $display("test level done");
    // Disconnected pin raises nothing; reconnecting routes it again.
    bus(1'b1, `ERPC_OFS_CONTROL, 32'h00000000);
    pin_low(1'b1);
    idle(10);
    check("isolated", cpu_request, 1'b0);
    bus(1'b0, `ERPC_OFS_CONTROL, 32'h0);
    check("control off", rd, 32'h00000000);
    bus(1'b1, `ERPC_OFS_CONTROL, 32'h00000040);
    idle(3);
    check("reconnected", cpu_request, 1'b1);
    pin_low(1'b0);
    bus(1'b0, `ERPC_OFS_STATUS, 32'h0);
    $display("test connect done");
    // Normal mode: edge select is already spent and cannot change.
    bus(1'b1, `ERPC_OFS_CONTROL, 32'h000000C0);
    bus(1'b0, `ERPC_OFS_CONTROL, 32'h0);
    check("write once", rd, 32'h00000040);
    bus(1'b0, `ERPC_OFS_STATUS, 32'h0);
    check("refused", rd, 32'h00000002);
    bus(1'b0, 4'h2, 32'h0);
    check("unmapped", rd, 32'h00000000);
    $display("test write once done");
    // Special mode: edge mode, latched fall, steady low ignored.
    @(posedge clk_sys_i);
    special_mode <= 1'b1;
    bus(1'b1, `ERPC_OFS_CONTROL, 32'h000000C0);
    bus(1'b0, `ERPC_OFS_CONTROL, 32'h0);
    check("special", rd, 32'h000000C0);
    idle(8);
    check("idle edge", cpu_request, 1'b0);
    pin_low(1'b1);
    idle(8);
    check("fall seen", cpu_request, 1'b1);
    pin_low(1'b0);
    idle(10);
    check("pending", cpu_request, 1'b1);
    pin_low(1'b1);
    idle(8);
    serve();
    idle(3);
    check("serviced", cpu_request, 1'b0);
    idle(10);
    check("steady low", cpu_request, 1'b0);
    pin_low(1'b0);
    idle(8);
    pin_low(1'b1);
    idle(8);
    check("second fall", cpu_request, 1'b1);
    bus(1'b1, `ERPC_OFS_SERVICE, 32'h00000001);
    idle(3);
    check("bus service", cpu_request, 1'b0);
    pin_low(1'b0);
    bus(1'b1, `ERPC_OFS_CONTROL, 32'h00000040);
    bus(1'b0, `ERPC_OFS_CONTROL, 32'h0);
    check("back level", rd, 32'h00000040);
    $display("test edge done");
    report_and_stop();
  end
endmodule : erpc_top_tb
